//--- bench/dual_adc_conversion_serial_readout_tb_top.sv
// Testbench joining device and host ends, checking results and gathered words
`default_nettype none
module dual_adc_conversion_serial_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                              clk_sys = 1'b0;
    logic                              rst = 1'b1;
    logic signed [17:0]                sampleA = 18'h00000;
    logic signed [17:0]                sampleB = 18'h00000;
    logic                              powerDown = 1'b0;
    logic                              run = 1'b0;
    logic                              zeroLatency = 1'b0;
    logic                              wordReady = 1'b0;
    logic                              stall = 1'b0;
    logic                              discard = 1'b1;
    logic                              wordValid;
    logic [adc_link_pkg::DATA_W-1:0]   wordA;
    logic [adc_link_pkg::DATA_W-1:0]   wordB;
    logic [adc_link_pkg::DATA_W-1:0]   resultA;
    logic [adc_link_pkg::DATA_W-1:0]   resultB;
    logic                              convertBusy;
    logic                              convDone;
    logic [31:0]                       seed = 32'h00000016;
    logic [31:0]                       expQ[$];
    logic [17:0]                       tableA[5] = '{18'h20000, 18'h00000, 18'h07fff, 18'h08000, 18'h1ffff};
    logic [17:0]                       tableB[5] = '{18'h1ffff, 18'h3ffff, 18'h38000, 18'h37fff, 18'h20000};
    int                                skipWords = 0;
    int                                mismatches = 0;
    int                                total_checks = 0;

    always #50 clk_sys = ~clk_sys;

    adc_link_if link ();

    dual_adc_device #(.SAMPLE_W(18)) dual_adc_device_i (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .link        (link.deviceEnd),
        .sampleA     (sampleA),
        .sampleB     (sampleB),
        .powerDown   (powerDown),
        .resultA     (resultA),
        .resultB     (resultB),
        .convertBusy (convertBusy),
        .convDone    (convDone)
    );

    dual_adc_host dual_adc_host_i (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .link        (link.hostEnd),
        .run         (run),
        .zeroLatency (zeroLatency),
        .wordValid   (wordValid),
        .wordA       (wordA),
        .wordB       (wordB),
        .wordReady   (wordReady)
    );

    dual_adc_link_checker dual_adc_link_checker_i (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .csN           (link.csN),
        .sclk          (link.sclk),
        .chanALane0Out (link.chanALane0Out),
        .chanALane1Out (link.chanALane1Out),
        .chanBLane0Out (link.chanBLane0Out),
        .chanBLane1Out (link.chanBLane1Out),
        .laneOeN       (link.laneOeN),
        .convertBusy   (convertBusy),
        .convDone      (convDone),
        .resultA       (resultA),
        .resultB       (resultB)
    );

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xorshift

    // Ideal code of an oversized sample: clamps at both full-scale ends
    function automatic logic [15:0] satCode(input logic signed [17:0] v);
        if (v > 18'sh07fff) begin
            return 16'h7fff;
        end
        if (v < 18'sh38000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction : satCode

    task automatic report(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : report

    task automatic compareResult(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp, "result pair");
    endtask : compareResult

    task automatic compareWord(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp, "word pair");
    endtask : compareWord

    // Receiver stalls at random, or wholly while a stage fills the buffer
    always @(posedge clk_sys) begin
        #2;
        seed = xorshift(seed);
        wordReady = !stall && seed[0];
    end

    // Judged at the falling edge, where every flop has settled
    always @(negedge clk_sys) begin
        if (!rst && convDone) begin
            compareResult({resultA, resultB}, {satCode(sampleA), satCode(sampleB)});
        end
        if (!rst && !discard && wordValid && wordReady) begin
            if (skipWords > 0) begin
                skipWords--;
            end else if (expQ.size() > 0) begin
                compareWord({wordA, wordB}, expQ.pop_front());
            end
        end
    end

    // Stop, change samples while idle, restart; the first three words may hold older samples
    task automatic runStage(input logic [17:0] valA, input logic [17:0] valB, input logic zl, input logic hold);
        int waitCount;
        discard = 1'b1;
        run = 1'b0;
        repeat (150) @(posedge clk_sys);
        #2;
        powerDown = 1'b1;
        @(posedge clk_sys);
        #2;
        powerDown = 1'b0;
        sampleA = valA;
        sampleB = valB;
        zeroLatency = zl;
        stall = hold;
        for (int k = 0; k < 4; k++) begin
            expQ.push_back({satCode(valA), satCode(valB)});
        end
        skipWords = 3;
        discard = 1'b0;
        run = 1'b1;
        repeat (300) @(posedge clk_sys);
        #2;
        stall = 1'b0;
        waitCount = 0;
        // Leave the loop off the edge so the next stage never races the sampling flops
        while (expQ.size() > 0 && waitCount < 3000) begin
            @(posedge clk_sys);
            #2;
            waitCount++;
        end
        if (expQ.size() > 0) begin
            mismatches++;
            $display("BAD t=%0t words missing", $time);
            expQ.delete();
        end
    endtask : runStage

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // Boundary samples first, then random ones; latency mode alternates
    initial begin
        repeat (4) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        for (int i = 0; i < 10; i++) begin
            if (i < 5) begin
                runStage(tableA[i], tableB[i], i[0], i == 1);
            end else begin
                runStage(seed[17:0], seed[31:14], i[0], 1'b0);
            end
        end
        print_verdict();
    end

    // Watchdog well beyond ten stages of about a thousand cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        $display("BAD t=%0t watchdog expired", $time);
        print_verdict();
    end
endmodule : dual_adc_conversion_serial_readout_tb_top
`default_nettype wire

//--- bench/dual_adc_link_checker.sv
// Checker for the pins of the converter link and the device's conversion status
`default_nettype none
module dual_adc_link_checker (
    input wire logic                             clk_sys,
    input wire logic                             rst,
    input wire logic                             csN,
    input wire logic                             sclk,
    input wire logic                             chanALane0Out,
    input wire logic                             chanALane1Out,
    input wire logic                             chanBLane0Out,
    input wire logic                             chanBLane1Out,
    input wire logic                             laneOeN,
    input wire logic                             convertBusy,
    input wire logic                             convDone,
    input wire logic [adc_link_pkg::DATA_W-1:0]  resultA,
    input wire logic [adc_link_pkg::DATA_W-1:0]  resultB
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // All four lanes seen together
    logic [3:0] lanes;
    assign lanes = {chanALane1Out, chanALane0Out, chanBLane1Out, chanBLane0Out};

    // Margins of one cycle cover the synchroniser's pipeline
    a_lanes_released: assert property (csN [*5] |-> laneOeN)
        else $error("lanes driven while select high");
    a_frame_opens: assert property ($fell(csN) |-> ##[2:4] !laneOeN)
        else $error("frame did not drive lanes");
    a_clock_still: assert property (csN |-> !sclk)
        else $error("serial clock moved outside a frame");
    a_lanes_steady: assert property ((!csN && !$rose(sclk)) [*5] |-> $stable(lanes))
        else $error("lanes changed without a launch edge");
    // Four quiet cycles after a start keep rises at least the cycle time apart
    a_start_spacing: assert property ($rose(csN) |=> !$rose(csN) [*4])
        else $error("conversion starts closer than the cycle time");
    a_busy_on_start: assert property ($rose(csN) && !convertBusy |-> ##[2:4] convertBusy)
        else $error("select rise did not start a conversion");
    a_done_in_time: assert property ($rose(convertBusy) |-> ##[3:5] convDone)
        else $error("conversion overran its time");
    a_done_pulse: assert property (convDone |=> !convDone)
        else $error("done pulse longer than one cycle");
    a_idle_after_done: assert property (convDone |-> ##[0:1] !convertBusy)
        else $error("no return to acquire after done");
    a_results_move: assert property (($changed(resultA) || $changed(resultB)) |-> convDone)
        else $error("results changed without done");
endmodule : dual_adc_link_checker
`default_nettype wire

//--- design/dual_adc_device.sv
// Device end of the dual converter link: conversion sequencer and two-lane serial readout
//
// Contract
// - Results are saturated 16-bit two's-complement codes
// - Acquire phase after reset, power-down, done
// - Select rise in acquire starts a conversion
// - Both channels capture on the same edge
// - Conversion timed by own clock only
// - Host spaces conversion starts by cycle time
// - Done hands over results, back to acquire
// - Result left-justified, split over two lanes
// - Select fall opens frame with latest result
// - Channel A and B lanes run in parallel
// - Select fall drives MSB lane1, next lane0
// - Each serial clock rise launches next pair
// - Zeros follow once all bits are out
// - Select rise ends frame, starts conversion
// - Select high time picks zero or one latency
// - Full rate needs one-sample-latency readout
// - Lanes released while select is high
`default_nettype none
module dual_adc_device #(
    parameter int SAMPLE_W    = 18,
    parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    adc_link_if.deviceEnd                    link,
    input  wire logic signed [SAMPLE_W-1:0]  sampleA,
    input  wire logic signed [SAMPLE_W-1:0]  sampleB,
    input  wire logic                        powerDown,
    output logic [adc_link_pkg::DATA_W-1:0]  resultA,
    output logic [adc_link_pkg::DATA_W-1:0]  resultB,
    output logic                             convertBusy,
    output logic                             convDone
);
    localparam int DW     = adc_link_pkg::DATA_W;
    localparam int LW     = adc_link_pkg::LANES;
    localparam int CONV_W = $clog2(CONV_CYCLES + 1);
    localparam logic [DW-1:0] MID = adc_link_pkg::MIDSCALE_CODE;

    // Refuse shapes the saturation and counter cannot serve
    if (SAMPLE_W < DW) begin : gBadSample
        $error("dual_adc_device: SAMPLE_W must be at least DATA_W");
    end
    if (CONV_CYCLES < 1) begin : gBadConv
        $error("dual_adc_device: CONV_CYCLES must be at least 1");
    end

    // Whole state of the device in one record
    typedef struct packed {
        logic [2:0]                 csPipe;    // [0] meta, [1] sync, [2] previous
        logic [2:0]                 sclkPipe;  // Same layout for the serial clock
        adc_link_pkg::phase_t       phase;
        logic [CONV_W-1:0]          convCnt;
        logic [DW-1:0]              heldA;     // Sample held during conversion
        logic [DW-1:0]              heldB;
        logic [DW-1:0]              resultA;   // Last completed conversion
        logic [DW-1:0]              resultB;
        logic [DW-1:0]              shiftA;    // Top two bits are the lanes
        logic [DW-1:0]              shiftB;
        logic                       laneOeN;
        logic                       doneInt;   // conversion_done_internal pulse
    } state_t;

    localparam state_t RESET_STATE = '{
        csPipe:   3'h7,
        sclkPipe: 3'h0,
        phase:    adc_link_pkg::ACQUIRE_PHASE,
        convCnt:  '0,
        heldA:    MID,
        heldB:    MID,
        resultA:  MID,
        resultB:  MID,
        shiftA:   MID,
        shiftB:   MID,
        laneOeN:  1'b1,
        doneInt:  1'b0
    };

    state_t cur;
    state_t next_state;
    logic   csRise;
    logic   csFall;
    logic   sclkRise;
    logic   doneNow;
    logic [DW-1:0] frameA;
    logic [DW-1:0] frameB;

    // Clamp a wide held sample to the code range; outside it the
    // full-scale codes stand, as a real quantiser would saturate
    function automatic logic [DW-1:0] toCode(input logic signed [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-DW:0] top;
        top = s[SAMPLE_W-1:DW-1];
        if (&top || ~|top) begin
            toCode = s[DW-1:0];
        end else if (s[SAMPLE_W-1]) begin
            toCode = adc_link_pkg::NEG_FULLSCALE_CODE;
        end else begin
            toCode = adc_link_pkg::POS_FULLSCALE_CODE;
        end
    endfunction : toCode

    // Drop the top lane pair and pull zeros in behind
    function automatic logic [DW-1:0] shiftPair(input logic [DW-1:0] w);
        shiftPair = {w[DW-LW-1:0], {LW{1'b0}}};
    endfunction : shiftPair

    always_comb begin
        next_state = cur;
        next_state.doneInt = 1'b0;

        // Pins come from the host's domain; only stage [1] and [2] are looked at
        next_state.csPipe   = {cur.csPipe[1:0], link.csN};
        next_state.sclkPipe = {cur.sclkPipe[1:0], link.sclk};
        csRise   = cur.csPipe[1] && !cur.csPipe[2];
        csFall   = !cur.csPipe[1] && cur.csPipe[2];
        sclkRise = cur.sclkPipe[1] && !cur.sclkPipe[2];

        // Conversion sequencer, timed by clk_sys and never by the serial clock
        doneNow = 1'b0;
        if (powerDown) begin
            // Any conversion in flight is abandoned, the old results stay
            next_state.phase   = adc_link_pkg::ACQUIRE_PHASE;
            next_state.convCnt = '0;
        end else begin
            unique case (cur.phase)
                adc_link_pkg::ACQUIRE_PHASE: begin
                    if (csRise) begin
                        next_state.phase   = adc_link_pkg::CONVERT_PHASE;
                        next_state.convCnt = '0;
                        // Both channels hold on the very same edge
                        next_state.heldA   = toCode(sampleA);
                        next_state.heldB   = toCode(sampleB);
                    end
                end
                adc_link_pkg::CONVERT_PHASE: begin
                    // A select rise here is ignored: the host broke its spacing
                    if (cur.convCnt == CONV_W'(CONV_CYCLES - 1)) begin
                        doneNow             = 1'b1;
                        next_state.phase    = adc_link_pkg::ACQUIRE_PHASE;
                        next_state.resultA  = cur.heldA;
                        next_state.resultB  = cur.heldB;
                        next_state.doneInt  = 1'b1;
                    end else begin
                        next_state.convCnt = cur.convCnt + CONV_W'(1);
                    end
                end
            endcase
        end

        // A conversion that ends in the frame's first cycle still counts
        frameA = doneNow ? cur.heldA : cur.resultA;
        frameB = doneNow ? cur.heldB : cur.resultB;

        // Serial readout; both channels run in lockstep
        if (csRise) begin
            next_state.laneOeN = 1'b1;
        end else if (csFall) begin
            next_state.laneOeN = 1'b0;
            next_state.shiftA  = frameA;
            next_state.shiftB  = frameB;
        end else if (sclkRise && !cur.laneOeN) begin
            next_state.shiftA = shiftPair(cur.shiftA);
            next_state.shiftB = shiftPair(cur.shiftB);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next_state;
        end
    end

    // Odd bits on lane 1, even bits on lane 0, all straight from flops
    assign link.chanALane1Out = cur.shiftA[DW-1];
    assign link.chanALane0Out = cur.shiftA[DW-2];
    assign link.chanBLane1Out = cur.shiftB[DW-1];
    assign link.chanBLane0Out = cur.shiftB[DW-2];
    assign link.laneOeN       = cur.laneOeN;

    // User-side view of the converter state
    assign resultA     = cur.resultA;
    assign resultB     = cur.resultB;
    assign convertBusy = (cur.phase == adc_link_pkg::CONVERT_PHASE);
    assign convDone    = cur.doneInt;
endmodule : dual_adc_device
`default_nettype wire

//--- design/dual_adc_host.sv
// Host end: makes chip select and serial clock, gathers both channel words
`default_nettype none
module dual_adc_host #(
    parameter int SCLK_HALF = adc_link_pkg::SCLK_HALF
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    adc_link_if.hostEnd                      link,
    input  wire logic                        run,
    input  wire logic                        zeroLatency,
    output logic                             wordValid,
    output logic [adc_link_pkg::DATA_W-1:0]  wordA,
    output logic [adc_link_pkg::DATA_W-1:0]  wordB,
    input  wire logic                        wordReady
);
    localparam int DW      = adc_link_pkg::DATA_W;
    localparam int CNT_W   = $clog2(2 * SCLK_HALF + 1);
    localparam int SINCE_W = 4;
    localparam logic [SINCE_W-1:0] SINCE_MAX = '1;

    if (SCLK_HALF < adc_link_pkg::SYNC_CYCLES) begin : gBadHalf
        $error("dual_adc_host: SCLK_HALF too short for the device synchroniser");
    end
    if (adc_link_pkg::ZL_HOLD_CYCLES > int'(SINCE_MAX)
            || adc_link_pkg::CYCLE_CYCLES > int'(SINCE_MAX)) begin : gBadSince
        $error("dual_adc_host: select high counter too narrow");
    end

    typedef struct packed {
        adc_link_pkg::host_state_t st;
        logic                      csN;
        logic                      sclk;
        logic [CNT_W-1:0]          cnt;
        logic [2:0]                pair;
        logic [SINCE_W-1:0]        sinceRise;
        logic [3:0]                laneMeta;
        logic [3:0]                laneSync;
        logic [DW-1:0]             accA;
        logic [DW-1:0]             accB;
        logic                      pushValid;
    } state_t;

    state_t cur;
    state_t next_state;
    logic   fifoReady;
    logic [SINCE_W-1:0] holdNeed;

    always_comb begin
        next_state = cur;
        // Lanes come from another clock domain
        next_state.laneMeta = {link.chanBLane1Out, link.chanBLane0Out, link.chanALane1Out, link.chanALane0Out};
        next_state.laneSync = cur.laneMeta;
        next_state.cnt      = cur.cnt + CNT_W'(1);
        if (cur.sinceRise != SINCE_MAX) begin
            next_state.sinceRise = cur.sinceRise + SINCE_W'(1);
        end
        // Long high pulse waits out the conversion for zero latency
        holdNeed = zeroLatency ? SINCE_W'(adc_link_pkg::ZL_HOLD_CYCLES)
                               : SINCE_W'(adc_link_pkg::CS_HIGH_CYCLES);
        unique case (cur.st)
            adc_link_pkg::HOST_HOLD: begin
                if (run && cur.sinceRise >= holdNeed
                        && cur.sinceRise >= SINCE_W'(adc_link_pkg::CYCLE_CYCLES)) begin
                    next_state.csN  = 1'b0;
                    next_state.st   = adc_link_pkg::HOST_LEAD;
                    next_state.cnt  = '0;
                    next_state.pair = '0;
                end
            end
            adc_link_pkg::HOST_LEAD,
            adc_link_pkg::HOST_LOW: begin
                if ((cur.st == adc_link_pkg::HOST_LEAD && cur.cnt == CNT_W'(2 * SCLK_HALF - 1))
                        || (cur.st == adc_link_pkg::HOST_LOW && cur.cnt == CNT_W'(SCLK_HALF - 1))) begin
                    // Capture just before the next launch edge
                    next_state.accA = {cur.accA[DW-3:0], cur.laneSync[1], cur.laneSync[0]};
                    next_state.accB = {cur.accB[DW-3:0], cur.laneSync[3], cur.laneSync[2]};
                    next_state.cnt  = '0;
                    if (cur.pair == 3'(adc_link_pkg::PAIRS - 1)) begin
                        next_state.csN       = 1'b1;
                        next_state.sinceRise = '0;
                        next_state.pushValid = 1'b1;
                        next_state.st        = adc_link_pkg::HOST_FLUSH;
                    end else begin
                        next_state.sclk = 1'b1;
                        next_state.pair = cur.pair + 3'h1;
                        next_state.st   = adc_link_pkg::HOST_HIGH;
                    end
                end
            end
            adc_link_pkg::HOST_HIGH: begin
                if (cur.cnt == CNT_W'(SCLK_HALF - 1)) begin
                    next_state.sclk = 1'b0;
                    next_state.cnt  = '0;
                    next_state.st   = adc_link_pkg::HOST_LOW;
                end
            end
            adc_link_pkg::HOST_FLUSH: begin
                // A full buffer stalls the next frame, no word is lost
                if (fifoReady) begin
                    next_state.pushValid = 1'b0;
                    next_state.st        = adc_link_pkg::HOST_HOLD;
                end
            end
            default: next_state.st = adc_link_pkg::HOST_HOLD;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur <= '{st: adc_link_pkg::HOST_HOLD, csN: 1'b1, sclk: 1'b0, cnt: '0, pair: '0,
                     sinceRise: SINCE_MAX, laneMeta: '0, laneSync: '0, accA: '0, accB: '0,
                     pushValid: 1'b0};
        end else begin
            cur <= next_state;
        end
    end

    assign link.csN  = cur.csN;
    assign link.sclk = cur.sclk;

    two_entry_buffer #(.W(2 * DW)) wordBuf (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .inValid  (cur.pushValid),
        .inData   ({cur.accA, cur.accB}),
        .inReady  (fifoReady),
        .outValid (wordValid),
        .outData  ({wordA, wordB}),
        .outReady (wordReady)
    );
endmodule : dual_adc_host
`default_nettype wire

//--- design/two_entry_buffer.sv
// Two-entry valid/ready buffer with registered outputs
`default_nettype none
module two_entry_buffer #(
    parameter int W = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    if (W < 1) begin : gBadWidth
        $error("two_entry_buffer: W must be at least 1");
    end

    typedef struct packed {
        logic [1:0]   count;
        logic [W-1:0] head;
        logic [W-1:0] tail;
        logic         notEmpty;
        logic         notFull;
    } state_t;

    state_t cur;
    state_t next_state;
    logic   push;
    logic   pop;

    // Head is always the oldest word so outData needs no mux
    always_comb begin
        next_state = cur;
        push = inValid && cur.notFull;
        pop  = outReady && cur.notEmpty;
        unique case (cur.count)
            2'h0: if (push) begin
                next_state.head  = inData;
                next_state.count = 2'h1;
            end
            2'h1: if (push && pop) begin
                next_state.head = inData;
            end else if (push) begin
                next_state.tail  = inData;
                next_state.count = 2'h2;
            end else if (pop) begin
                next_state.count = 2'h0;
            end
            2'h2: if (pop) begin
                next_state.head  = cur.tail;
                next_state.count = 2'h1;
            end
            default: next_state.count = 2'h0;
        endcase
        next_state.notEmpty = (next_state.count != 2'h0);
        next_state.notFull  = (next_state.count != 2'h2);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur <= '{count: 2'h0, head: '0, tail: '0, notEmpty: 1'b0, notFull: 1'b1};
        end else begin
            cur <= next_state;
        end
    end

    assign inReady  = cur.notFull;
    assign outValid = cur.notEmpty;
    assign outData  = cur.head;
endmodule : two_entry_buffer
`default_nettype wire

//--- pkg/adc_link_if.sv
// Pin-level link between the converter and its host
`default_nettype none
interface adc_link_if;
    logic csN;            // Chip select, active low, made by the host
    logic sclk;           // Serial clock, made by the host
    logic chanALane0Out;  // Channel A even bits
    logic chanALane1Out;  // Channel A odd bits
    logic chanBLane0Out;  // Channel B even bits
    logic chanBLane1Out;  // Channel B odd bits
    logic laneOeN;        // Low while the device drives all four lanes

    modport deviceEnd (
        input  csN,
        input  sclk,
        output chanALane0Out,
        output chanALane1Out,
        output chanBLane0Out,
        output chanBLane1Out,
        output laneOeN
    );

    modport hostEnd (
        output csN,
        output sclk,
        input  chanALane0Out,
        input  chanALane1Out,
        input  chanBLane0Out,
        input  chanBLane1Out,
        input  laneOeN
    );
endinterface : adc_link_if
`default_nettype wire

//--- pkg/adc_link_pkg.sv
// Shared constants and types for the dual converter serial link
`default_nettype none
package adc_link_pkg;
    // Word layout
    localparam int DATA_W = 16;
    localparam int LANES  = 2;
    localparam int PAIRS  = DATA_W / LANES;
    localparam logic [DATA_W-1:0] NEG_FULLSCALE_CODE = 16'h8000;
    localparam logic [DATA_W-1:0] MIDSCALE_CODE      = 16'h0000;
    localparam logic [DATA_W-1:0] POS_FULLSCALE_CODE = 16'h7fff;

    // Times in ns and their cycle counts at clk_sys
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS  = 422;   // Longest time, rounds down
    localparam int CYCLE_TIME_NS = 488;   // Least time, rounds up
    localparam int CS_HIGH_NS    = 15;    // Least time, rounds up
    localparam int CONV_RAW      = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CONV_CYCLES   = (CONV_RAW < 1) ? 1 : CONV_RAW;
    localparam int CYCLE_CYCLES  = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_HIGH_CYCLES = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Two-flop synchroniser plus edge detect, seen from the far end
    localparam int SYNC_CYCLES    = 3;
    localparam int ZL_HOLD_CYCLES = CONV_CYCLES + SYNC_CYCLES;
    localparam int SCLK_HALF      = 4;     // Half period of the made serial clock

    // Conversion sequencer phases
    typedef enum logic {
        ACQUIRE_PHASE = 1'b0,
        CONVERT_PHASE = 1'b1
    } phase_t;

    // Host frame sequencer
    typedef enum logic [2:0] {
        HOST_HOLD  = 3'h0,
        HOST_LEAD  = 3'h1,
        HOST_HIGH  = 3'h2,
        HOST_LOW   = 3'h3,
        HOST_FLUSH = 3'h4
    } host_state_t;
endpackage : adc_link_pkg
`default_nettype wire
